// file: hw/lrat_pkg.sv
// lrat_pkg: constants and carriers for the line relay auxiliary trip logic
// assumes a 10 MHz hclk and a 1 ms sample tick derived from it
package lrat_pkg;
    // timing
    localparam int CLK_NS         = 100;
    localparam int TICK_NS        = 1000000;
    localparam int TICK_CYC       = TICK_NS / CLK_NS;
    localparam int CW             = 16;
    localparam logic [15:0] LP_ARM_MS     = 16'h0096;  // 150 ms
    localparam logic [15:0] LP_FAST_MS    = 16'h0028;  // 40 ms
    localparam logic [15:0] LP_DLY_MS     = 16'h002d;  // 45 ms
    localparam logic [15:0] POLE_DROP_MS  = 16'h005a;  // 90 ms
    localparam logic [15:0] OSB_INIT_MS   = 16'h001e;  // 30 ms
    localparam logic [15:0] OSB_DROP_MS   = 16'h0032;  // 50 ms

    // register byte offsets
    localparam logic [7:0] CTRL_OFS   = 8'h00;
    localparam logic [7:0] RODSEC_OFS = 8'h04;
    localparam logic [7:0] OSBADP_OFS = 8'h08;
    localparam logic [7:0] STAT_OFS   = 8'h0c;

    // ctrl fields
    localparam int CTRL_BYP    = 0;
    localparam int CTRL_SEL    = 1;
    localparam int CTRL_ZEN    = 3;
    localparam int CTRL_SPB    = 7;
    localparam logic [7:0]  CTRL_RST   = 8'h78;
    localparam logic [15:0] RODSEC_RST = 16'h0014;
    localparam logic [7:0]  OSB_STEP_RST  = 8'h05;
    localparam logic [7:0]  OSB_FLOOR_RST = 8'h0a;

    typedef enum logic [1:0] {
        BLOCK_EVERYTHING          = 2'b00,
        BLOCK_DISTANCE_ONLY       = 2'b01,
        BLOCK_PHASE_DISTANCE_ONLY = 2'b10,
        BLOCK_NOTHING             = 2'b11
    } lrat_sel_e;

    typedef struct packed {
        logic       all_open;
        logic       volt_high;
        logic       i1_pickup;
        logic       z2_phase;
        logic       z2_ground;
        logic [2:0] pole_open;
        logic [2:0] z2g_phase;
        logic       fault_det;
        logic [2:0] charge;
        logic       bal3_fault;
        logic [2:0] swing_blocking_characteristic;
        logic [2:0] mt;
    } lrat_in_s;

    typedef struct packed {
        logic       lp_armed;
        logic       lp_trip;
        logic       backup_bypass;
        logic [2:0] sp_enable;
        logic [2:0] sp_trip;
        logic       rod_trip;
        logic       osb_block;
        logic       block_all;
        logic [3:0] block_gnd_zone;
        logic [3:0] block_ph_zone;
    } lrat_out_s;
endpackage

// file: hw/lrat_top.sv
// lrat_top: line pickup, remote-open detector and out-of-step blocking
// assumes relay inputs are synchronous to hclk; settings over AHB-Lite
`timescale 1ns/1ps

module lrat_top #(
    parameter int TICK_CYC = lrat_pkg::TICK_CYC
) (
    // clock and reset
    input  wire logic                hclk,
    input  wire logic                hresetn,
    // ahb-lite slave
    input  wire logic                hsel,
    input  wire logic [31:0]         haddr,
    input  wire logic [1:0]          htrans,
    input  wire logic                hwrite,
    input  wire logic [2:0]          hsize,
    input  wire logic [31:0]         hwdata,
    input  wire logic                hready,
    output logic                     hreadyout,
    output logic [31:0]              hrdata,
    output logic                     hresp,
    // relay logic
    input  wire lrat_pkg::lrat_in_s  relay_in,
    output lrat_pkg::lrat_out_s      relay_out
);
    import lrat_pkg::*;

    localparam int TW = $clog2(TICK_CYC);

    default clocking cb @(posedge hclk); endclocking
    default disable iff (!hresetn);

    function automatic logic [15:0] sat_inc(input logic [15:0] c);
        sat_inc = (c == 16'hffff) ? c : c + 16'h0001;
    endfunction

    function automatic logic [3:0] zone_blk(input logic out_of_step_block,
                                            input logic [1:0] sel,
                                            input logic [3:0] zen,
                                            input logic phase);
        logic pick;
        pick = (sel == BLOCK_DISTANCE_ONLY) ||
               (phase && sel == BLOCK_PHASE_DISTANCE_ONLY);
        if (!out_of_step_block)
            zone_blk = 4'h0;
        else if (sel == BLOCK_EVERYTHING)
            zone_blk = 4'hf;
        else
            zone_blk = pick ? zen : 4'h0;
    endfunction

    // bus state
    logic [7:0]  ctrl_r;
    logic [15:0] rod_sec_r;
    logic [7:0]  osb_step_r;
    logic [7:0]  osb_floor_r;
    logic        wr_pend_r;
    logic [7:0]  wr_addr_r;
    logic        hreadyout_r;
    logic [31:0] hrdata_r;

    // timers and flags
    logic [TW-1:0] div_r;
    logic          tick_r;
    logic [15:0]   arm_cnt_r;
    logic [15:0]   vh_cnt_r;
    logic [15:0]   dly_cnt_r;
    logic [15:0]   pdrop_cnt_r [3];
    logic [15:0]   sec_cnt_r;
    logic [15:0]   tl1_cnt_r;
    logic [15:0]   drop_cnt_r;
    logic [15:0]   pick_r;
    logic          armed_r;
    logic          lp_trip_r;
    logic          bypass_r;
    logic [2:0]    sp_en_r;
    logic [2:0]    sp_trip_r;
    logic          rod_latch_r;
    logic          rod_trip_r;
    logic          exp_seen_r;
    logic          osb_r;
    logic          blk_all_r;
    logic [3:0]    blk_gnd_r;
    logic [3:0]    blk_ph_r;

    // settings views
    logic       tmr_bypass;
    logic [1:0] blk_sel;
    logic [3:0] zone_en;
    logic       sp_build;
    assign tmr_bypass = ctrl_r[CTRL_BYP];
    assign blk_sel    = ctrl_r[CTRL_SEL +: 2];
    assign zone_en    = ctrl_r[CTRL_ZEN +: 4];
    assign sp_build   = ctrl_r[CTRL_SPB];

    // ---------------- ahb-lite slave ----------------
    logic       acc;
    logic [7:0] aofs;
    logic       aok;
    assign acc  = hsel && htrans[1] && hready;
    assign aofs = haddr[7:0];
    assign aok  = (haddr[31:8] == 24'h000000);

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            wr_pend_r <= 1'b0;
            wr_addr_r <= 8'h00;
        end else begin
            wr_pend_r <= acc && hwrite && aok;
            wr_addr_r <= aofs;
        end
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            ctrl_r      <= CTRL_RST;
            rod_sec_r   <= RODSEC_RST;
            osb_step_r  <= OSB_STEP_RST;
            osb_floor_r <= OSB_FLOOR_RST;
        end else if (wr_pend_r) begin
            unique case (wr_addr_r)
                CTRL_OFS:   ctrl_r    <= hwdata[7:0];
                RODSEC_OFS: rod_sec_r <= hwdata[15:0];
                OSBADP_OFS: begin
                    osb_step_r  <= hwdata[7:0];
                    osb_floor_r <= hwdata[15:8];
                end
                default: ;
            endcase
        end
    end

    logic [31:0] rd_val;
    always_comb begin
        rd_val = 32'h00000000;
        unique case (aofs)
            CTRL_OFS:   rd_val = {24'h000000, ctrl_r};
            RODSEC_OFS: rd_val = {16'h0000, rod_sec_r};
            OSBADP_OFS: rd_val = {16'h0000, osb_floor_r, osb_step_r};
            STAT_OFS:   rd_val = {8'h00, pick_r[7:0], 8'h00, 1'b0, sp_en_r,
                                  osb_r, rod_latch_r, lp_trip_r, armed_r};
            default:    rd_val = 32'h00000000;
        endcase
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            hrdata_r    <= 32'h00000000;
            hreadyout_r <= 1'b0;
        end else begin
            hreadyout_r <= 1'b1;
            if (acc && !hwrite)
                hrdata_r <= aok ? rd_val : 32'h00000000;
        end
    end

    assign hreadyout = hreadyout_r;
    assign hrdata    = hrdata_r;
    assign hresp     = 1'b0;

    // ---------------- 1 ms tick ----------------
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            div_r  <= '0;
            tick_r <= 1'b0;
        end else if (div_r == TW'(TICK_CYC - 1)) begin
            div_r  <= '0;
            tick_r <= 1'b1;
        end else begin
            div_r  <= div_r + TW'(1);
            tick_r <= 1'b0;
        end
    end

    // ---------------- line pickup ----------------
    logic fast_rst;
    logic lp_fault;
    logic z2_any;
    assign fast_rst = (vh_cnt_r == LP_FAST_MS);
    assign lp_fault = armed_r && relay_in.i1_pickup;
    assign z2_any   = relay_in.z2_phase || relay_in.z2_ground;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            arm_cnt_r <= 16'h0000;
        else if (!relay_in.all_open)
            arm_cnt_r <= 16'h0000;
        else if (tick_r && arm_cnt_r < LP_ARM_MS)
            arm_cnt_r <= sat_inc(arm_cnt_r);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            vh_cnt_r <= 16'h0000;
        else if (!relay_in.volt_high || !armed_r)
            vh_cnt_r <= 16'h0000;
        else if (tick_r && vh_cnt_r < LP_FAST_MS)
            vh_cnt_r <= sat_inc(vh_cnt_r);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            armed_r <= 1'b0;
        else if (fast_rst)
            armed_r <= 1'b0;
        else if (arm_cnt_r == LP_ARM_MS)
            armed_r <= 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            dly_cnt_r <= 16'h0000;
        else if (!lp_fault)
            dly_cnt_r <= 16'h0000;
        else if (tick_r && dly_cnt_r < LP_DLY_MS)
            dly_cnt_r <= sat_inc(dly_cnt_r);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            lp_trip_r <= 1'b0;
            bypass_r  <= 1'b0;
        end else begin
            // zone 2 path ignores the current detector
            lp_trip_r <= (armed_r && z2_any) ||
                         (lp_fault && (tmr_bypass ||
                                       dly_cnt_r == LP_DLY_MS));
            bypass_r  <= armed_r;
        end
    end

    arm_pickup_a: assert property ($rose(armed_r) |->
        $past(arm_cnt_r) == LP_ARM_MS) else $error("arming before 150 ms");
    byp_trip_a: assert property (lp_fault && tmr_bypass |=> lp_trip_r)
        else $error("bypass trip missing");
    dly_trip_a: assert property ($rose(lp_trip_r) && !$past(tmr_bypass) &&
        !$past(armed_r && z2_any) |-> $past(dly_cnt_r) == LP_DLY_MS)
        else $error("delayed trip early");
    z2_trip_a: assert property (armed_r && z2_any |=> lp_trip_r)
        else $error("zone 2 pickup trip missing");
    fast_rst_a: assert property (fast_rst |=> !armed_r)
        else $error("fast reset ignored");

    // ---------------- single pole pickup ----------------
    genvar gi;
    generate
        for (gi = 0; gi < 3; gi++) begin : g_pole
            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn)
                    pdrop_cnt_r[gi] <= POLE_DROP_MS;
                else if (relay_in.pole_open[gi])
                    pdrop_cnt_r[gi] <= 16'h0000;
                else if (tick_r && pdrop_cnt_r[gi] < POLE_DROP_MS)
                    pdrop_cnt_r[gi] <= sat_inc(pdrop_cnt_r[gi]);
            end

            logic en;
            assign en = relay_in.pole_open[gi] ||
                        pdrop_cnt_r[gi] < POLE_DROP_MS;

            always_ff @(posedge hclk or negedge hresetn) begin
                if (!hresetn) begin
                    sp_en_r[gi]   <= 1'b0;
                    sp_trip_r[gi] <= 1'b0;
                end else begin
                    sp_en_r[gi]   <= sp_build && en;
                    sp_trip_r[gi] <= sp_build && en &&
                                     relay_in.z2g_phase[gi];
                end
            end
        end
    endgenerate

    pole_en_a: assert property (sp_build && relay_in.pole_open[0] |=>
        sp_en_r[0]) else $error("open pole not enabled");
    pole_drop_a: assert property (pdrop_cnt_r[1] == POLE_DROP_MS &&
        !relay_in.pole_open[1] |=> !sp_en_r[1])
        else $error("pole enable held past 90 ms");

    // ---------------- remote-open detector ----------------
    logic chg_any;
    logic rod_cond;
    assign chg_any  = |relay_in.charge;
    assign rod_cond = !rod_latch_r && relay_in.fault_det && chg_any &&
                      !relay_in.bal3_fault;

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            rod_latch_r <= 1'b0;
        else if (!chg_any)
            rod_latch_r <= 1'b0;
        else if (!relay_in.fault_det)
            rod_latch_r <= 1'b1;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            sec_cnt_r <= 16'h0000;
        else if (!rod_cond)
            sec_cnt_r <= 16'h0000;
        else if (tick_r && sec_cnt_r < rod_sec_r)
            sec_cnt_r <= sat_inc(sec_cnt_r);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            rod_trip_r <= 1'b0;
        else
            rod_trip_r <= rod_cond && sec_cnt_r >= rod_sec_r;
    end

    sequence rod_sealed_s;
        rod_latch_r && chg_any;
    endsequence
    rod_block_a: assert property (rod_sealed_s |=> !rod_trip_r)
        else $error("sealed latch did not block");
    rod_fd_a: assert property (relay_in.fault_det && !rod_latch_r |=>
        !rod_latch_r) else $error("latch set during fault");
    rod_bal_a: assert property (relay_in.bal3_fault |=> !rod_trip_r)
        else $error("trip on balanced fault");

    // ---------------- out-of-step blocking ----------------
    logic [2:0]  pair;
    logic        osb_en;
    logic        mob_any;
    logic        expire;
    logic        osb_clr;
    logic [15:0] floor16;
    logic [15:0] step16;
    assign pair    = relay_in.swing_blocking_characteristic & ~relay_in.mt &
                     {3{~|relay_in.pole_open}};
    assign osb_en  = |pair;
    assign mob_any = |relay_in.swing_blocking_characteristic;
    assign expire  = osb_en && !exp_seen_r && tl1_cnt_r >= pick_r;
    assign osb_clr = osb_r && !mob_any && drop_cnt_r == OSB_DROP_MS;
    assign floor16 = {8'h00, osb_floor_r};
    assign step16  = {8'h00, osb_step_r};

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            tl1_cnt_r <= 16'h0000;
        else if (!osb_en)
            tl1_cnt_r <= 16'h0000;
        else if (tick_r && tl1_cnt_r < pick_r)
            tl1_cnt_r <= sat_inc(tl1_cnt_r);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            exp_seen_r <= 1'b0;
        else if (!osb_en)
            exp_seen_r <= 1'b0;
        else if (expire)
            exp_seen_r <= 1'b1;
    end

    // one slip cycle per timer energisation
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            pick_r <= OSB_INIT_MS;
        else if (osb_clr)
            pick_r <= OSB_INIT_MS;
        else if (expire)
            pick_r <= (pick_r <= floor16 + step16) ? floor16 :
                      pick_r - step16;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            drop_cnt_r <= 16'h0000;
        else if (mob_any || !osb_r)
            drop_cnt_r <= 16'h0000;
        else if (tick_r && drop_cnt_r < OSB_DROP_MS)
            drop_cnt_r <= sat_inc(drop_cnt_r);
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn)
            osb_r <= 1'b0;
        else if (expire)
            osb_r <= 1'b1;
        else if (osb_clr)
            osb_r <= 1'b0;
    end

    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            blk_all_r <= 1'b0;
            blk_gnd_r <= 4'h0;
            blk_ph_r  <= 4'h0;
        end else begin
            blk_all_r <= osb_r && blk_sel == BLOCK_EVERYTHING;
            blk_gnd_r <= zone_blk(osb_r, blk_sel, zone_en, 1'b0);
            blk_ph_r  <= zone_blk(osb_r, blk_sel, zone_en, 1'b1);
        end
    end

    osb_timer_a: assert property ($rose(osb_r) |-> $past(osb_en) &&
        $past(tl1_cnt_r) >= $past(pick_r)) else $error("block without expiry");
    osb_seal_a: assert property (osb_r && mob_any |=> osb_r)
        else $error("seal-in lost");
    osb_drop_a: assert property ($fell(osb_r) |-> $past(drop_cnt_r) ==
        OSB_DROP_MS && !$past(mob_any)) else $error("block dropped early");
    osb_first_a: assert property (!osb_r |-> pick_r == OSB_INIT_MS)
        else $error("first slip pickup not 30 ms");
    blk_none_a: assert property (blk_sel == BLOCK_NOTHING |=>
        !blk_all_r && blk_gnd_r == 4'h0 && blk_ph_r == 4'h0)
        else $error("block while selection is none");
    blk_zone_a: assert property (osb_r && blk_sel == BLOCK_PHASE_DISTANCE_ONLY
        |=> blk_ph_r == $past(zone_en) && blk_gnd_r == 4'h0)
        else $error("phase zone block mismatch");

    // ---------------- outputs ----------------
    assign relay_out.lp_armed       = armed_r;
    assign relay_out.lp_trip        = lp_trip_r;
    assign relay_out.backup_bypass  = bypass_r;
    assign relay_out.sp_enable      = sp_en_r;
    assign relay_out.sp_trip        = sp_trip_r;
    assign relay_out.rod_trip       = rod_trip_r;
    assign relay_out.osb_block      = osb_r;
    assign relay_out.block_all      = blk_all_r;
    assign relay_out.block_gnd_zone = blk_gnd_r;
    assign relay_out.block_ph_zone  = blk_ph_r;
endmodule

// file: testbench/lrat_relay_model.sv
// lrat_relay_model: stands in for distance elements, fault detector, breaker status
// assumes the bench presents the wanted element states on scene; all same-clock levels
`timescale 1ns/1ps
module lrat_relay_model
    import lrat_pkg::*;
(
    // clock and reset
    input  wire logic                hclk,
    input  wire logic                hresetn,
    // wanted element states
    input  wire lrat_pkg::lrat_in_s  scene,
    // element outputs toward the block
    output lrat_pkg::lrat_in_s       relay_in
);
    // elements re-evaluate on every sample, so outputs lag the scene by one edge
    always_ff @(posedge hclk or negedge hresetn) begin
        if (!hresetn) begin
            relay_in <= '0;
        end else begin
            relay_in <= scene;
        end
    end
endmodule

// file: testbench/line_relay_aux_trip_logic_bench.sv
// line_relay_aux_trip_logic_bench: settings over the bus, element scenes, trip checks
// assumes lrat_top with a short tick (10 clocks per ms) and a zero-wait slave
`timescale 1ns/1ps
module line_relay_aux_trip_logic_bench;
    import lrat_pkg::*;
    localparam int TK = 10;
    logic        hclk;
    logic        hresetn;
    logic        hsel;
    logic [31:0] haddr;
    logic [1:0]  htrans;
    logic        hwrite;
    logic [31:0] hwdata;
    logic        hreadyout;
    logic [31:0] hrdata;
    logic        hresp;
    lrat_in_s    scene;
    lrat_in_s    relay_in;
    lrat_out_s   relay_out;
    logic [31:0] rd;
    int          bad_count;
    int          n_checks;

    lrat_relay_model u_model (.hclk(hclk), .hresetn(hresetn), .scene(scene),
                              .relay_in(relay_in));
    lrat_top #(.TICK_CYC(TK)) DUT (
        .hclk(hclk), .hresetn(hresetn), .hsel(hsel), .haddr(haddr), .htrans(htrans),
        .hwrite(hwrite), .hsize(3'h2), .hwdata(hwdata), .hready(hreadyout),
        .hreadyout(hreadyout), .hrdata(hrdata), .hresp(hresp),
        .relay_in(relay_in), .relay_out(relay_out));

    always #50 hclk = ~hclk;

    task automatic end_of_test();
        $display("checks %0d errors %0d", n_checks, bad_count);
        if (bad_count == 0 && n_checks > 0) begin
            $display("Result: passed");
        end else begin
            $display("Result: failed");
        end
        $finish;
    endtask

    task automatic check(input string nm, input logic [31:0] exp, input logic [31:0] got);
        n_checks++;
        if (got !== exp) begin
            $display("Error %s expected %h seen %h", nm, exp, got);
            bad_count++;
        end
    endtask

    // one single transfer; called just after a rising edge
    task automatic bus(input logic wr, input logic [31:0] a, input logic [31:0] wd);
        hsel   <= 1'b1;
        haddr  <= a;
        htrans <= 2'b10;
        hwrite <= wr;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        hsel   <= 1'b0;
        htrans <= 2'b00;
        hwdata <= wd;
        @(posedge hclk);
        while (hreadyout !== 1'b1) @(posedge hclk);
        rd = hrdata;
    endtask

    task automatic wait_ms(input int n);
        repeat (n * TK) @(posedge hclk);
    endtask

    task automatic settle();
        repeat (4) @(posedge hclk);
    endtask

    initial begin
        #5_000_000;
        bad_count++;
        end_of_test();
    end

    initial begin
        hclk = 0; hresetn = 0; hsel = 0; haddr = '0; htrans = 2'b00;
        hwrite = 0; hwdata = '0; scene = '0; bad_count = 0; n_checks = 0;
        repeat (12) @(posedge hclk);
        hresetn <= 1'b1;
        @(posedge hclk);
        // reset values and unmapped places
        bus(0, 32'h0, 0);     check("ctrl", 32'h78, rd);
        bus(0, 32'h4, 0);     check("rodsec", 32'h14, rd);
        bus(0, 32'h8, 0);     check("osbadp", 32'h0a05, rd);
        bus(0, 32'h10, 0);    check("unmapped", 32'h0, rd);
        bus(1, 32'h104, 32'hffff); bus(0, 32'h104, 0); check("high addr", 32'h0, rd);
        check("hresp", 32'h0, {31'h0, hresp});
        // arming after all poles open
        scene.all_open <= 1'b1;
        wait_ms(140);    check("armed early", 0, relay_out.lp_armed);
        wait_ms(20);     check("armed", 1, relay_out.lp_armed);
        bus(0, 32'hc, 0); check("stat armed", 1, rd[0]);
        // bypass trip
        bus(1, 32'h0, 32'h79);
        scene.i1_pickup <= 1'b1;
        settle();        check("bypass trip", 1, relay_out.lp_trip);
        check("bypass path", 1, relay_out.backup_bypass);
        scene.i1_pickup <= 1'b0;
        settle();        check("trip drop", 0, relay_out.lp_trip);
        // delayed trip
        bus(1, 32'h0, 32'h78);
        scene.i1_pickup <= 1'b1;
        wait_ms(40);     check("delay early", 0, relay_out.lp_trip);
        wait_ms(10);     check("delay trip", 1, relay_out.lp_trip);
        scene.i1_pickup <= 1'b0;
        settle();
        // zone 2 while armed, no current detector
        scene.z2_phase <= 1'b1;
        settle();        check("z2 trip", 1, relay_out.lp_trip);
        scene.z2_phase <= 1'b0;
        settle();        check("z2 drop", 0, relay_out.lp_trip);
        // fast reset by healthy voltages
        scene.all_open  <= 1'b0;
        scene.volt_high <= 1'b1;
        wait_ms(35);     check("fast early", 1, relay_out.lp_armed);
        wait_ms(10);     check("fast reset", 0, relay_out.lp_armed);
        scene.z2_ground <= 1'b1;
        settle();        check("no trip off", 0, relay_out.lp_trip);
        scene.z2_ground <= 1'b0;
        scene.volt_high <= 1'b0;
        // single-phase pole timers
        bus(1, 32'h0, 32'hf8);
        scene.pole_open <= 3'b001;
        scene.z2g_phase <= 3'b001;
        settle();        check("sp enable", 3'b001, relay_out.sp_enable);
        check("sp trip", 3'b001, relay_out.sp_trip);
        scene.pole_open <= 3'b000;
        wait_ms(85);     check("sp hold", 3'b001, relay_out.sp_enable);
        wait_ms(10);     check("sp drop", 3'b000, relay_out.sp_enable);
        check("sp trip off", 3'b000, relay_out.sp_trip);
        scene.z2g_phase <= 3'b000;
        // remote-open detector
        bus(1, 32'h0, 32'h78);
        bus(1, 32'h4, 32'h0a);
        scene.fault_det <= 1'b1;
        scene.charge    <= 3'b010;
        wait_ms(5);      check("rod early", 0, relay_out.rod_trip);
        wait_ms(10);     check("rod trip", 1, relay_out.rod_trip);
        scene.fault_det <= 1'b0;
        scene.charge    <= 3'b000;
        wait_ms(2);      check("rod drop", 0, relay_out.rod_trip);
        scene.charge    <= 3'b100;
        wait_ms(2);
        bus(0, 32'hc, 0); check("rod latch", 1, rd[2]);
        scene.fault_det <= 1'b1;
        wait_ms(20);     check("rod blocked", 0, relay_out.rod_trip);
        scene.fault_det <= 1'b0;
        scene.charge    <= 3'b000;
        wait_ms(2);
        bus(0, 32'hc, 0); check("latch clear", 0, rd[2]);
        scene.fault_det  <= 1'b1;
        scene.charge     <= 3'b001;
        scene.bal3_fault <= 1'b1;
        wait_ms(20);     check("rod balanced", 0, relay_out.rod_trip);
        scene.fault_det  <= 1'b0;
        scene.charge     <= 3'b000;
        scene.bal3_fault <= 1'b0;
        wait_ms(2);
        // out-of-step on pair B-C
        scene.swing_blocking_characteristic <= 3'b010;
        wait_ms(25);     check("osb early", 0, relay_out.osb_block);
        wait_ms(10);     check("osb set", 1, relay_out.osb_block);
        bus(0, 32'hc, 0); check("osb pickup", 8'h19, rd[23:16]);
        // further slips step the pickup down to the floor
        repeat (4) begin
            scene.swing_blocking_characteristic <= 3'b000;
            wait_ms(2);
            scene.swing_blocking_characteristic <= 3'b010;
            wait_ms(30);
        end
        check("osb held", 1, relay_out.osb_block);
        bus(0, 32'hc, 0); check("osb floor", 8'h0a, rd[23:16]);
        for (int s = 0; s < 4; s++) begin
            bus(1, 32'h0, 32'h28 | (s << 1));
            settle();
            check("blk all", (s == 0), relay_out.block_all);
            if (s != 0) begin
                check("blk gnd", (s == 1) ? 4'h5 : 4'h0, relay_out.block_gnd_zone);
                check("blk ph", (s < 3) ? 4'h5 : 4'h0, relay_out.block_ph_zone);
            end else begin
                check("blk all gnd", 4'hf, relay_out.block_gnd_zone);
                check("blk all ph", 4'hf, relay_out.block_ph_zone);
            end
        end
        bus(1, 32'h0, 32'h78);
        scene.swing_blocking_characteristic <= 3'b000;
        wait_ms(45);     check("osb hold", 1, relay_out.osb_block);
        wait_ms(10);     check("osb drop", 0, relay_out.osb_block);
        bus(0, 32'hc, 0); check("osb restore", 8'h1e, rd[23:16]);
        scene.swing_blocking_characteristic <= 3'b001;
        scene.mt  <= 3'b001;
        wait_ms(40);     check("osb mt", 0, relay_out.osb_block);
        scene.mt        <= 3'b000;
        scene.pole_open <= 3'b100;
        wait_ms(40);     check("osb pole", 0, relay_out.osb_block);
        scene <= '0;
        settle();
        end_of_test();
    end
endmodule
